// ==== logic/hv_io_cfg.svh ====
// Holds addresses, widths and reset values of the driver override bank.
// Assumes inclusion by bare name from the package and the design file.
`ifndef HV_IO_CFG_SVH
`define HV_IO_CFG_SVH
`define ADDR_W 8
`define DATA_W 8
`define PINS 8
`define OFS_OL_THRESH 8'h4a
`define OFS_HS_FORCE_OFF 8'h71
`define OFS_LS_FORCE_OFF 8'h72
`define OFS_NV_UNLOCK 8'h7e
`define OFS_NV_STATUS 8'h7f
`define NV_UNLOCK_KEY 8'ha5
`define RST_OL_THRESH 8'h00
`define FACTORY_FORCE_OFF 8'h00
`define ZERO_BYTE 8'h00
`endif

// ==== logic/hv_io_pkg.sv ====
// Types for the high-voltage pin override bank.
// Assumes hv_io_cfg.svh on the include path.
`default_nettype none
`include "hv_io_cfg.svh"
package hv_io_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [`PINS-1:0] hs_req;
    logic [`PINS-1:0] ls_req;
  } drv_req_t;
  typedef enum logic [1:0] {
    NV_LOCKED = 2'b01,
    NV_OPEN = 2'b10
  } nv_state_t;
endpackage
`default_nettype wire

// ==== logic/hv_io_driver_override_config.sv ====
// Register bank for pin open-load thresholds and driver force-off bits.
// Assumes a single clock, synchronous reset and a one-cycle register port.
// How it works
// - Pins 8..5 threshold fields, two bits each
// - High-side override 0: pin request passes
// - High-side override 1: high-side driver off
// - High-side bits: pin8 bit7 down to pin1
// - Low-side override 0: pin request passes
// - Low-side override 1: low-side driver off
// - Low-side bits: pin8 bit7, pin4 bit3
// - Override writes need the unlock procedure
// - Low-side pins 3..1 at bits 2..0
//
// The plain strobed port was left to the implementer.
`default_nettype none
`include "hv_io_cfg.svh"
module hv_io_driver_override_config (
  input wire logic clk,
  input wire logic rst,
  input wire hv_io_pkg::reg_req_t req,
  output logic [`DATA_W-1:0] rdata,
  input wire hv_io_pkg::drv_req_t pin_req,
  output logic [`PINS-1:0] hs_drive,
  output logic [`PINS-1:0] ls_drive,
  output logic [2*`PINS/2-1:0] open_load_threshold_sel
);
  import hv_io_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [`DATA_W-1:0] ol_thresh_ff;
  logic [`PINS-1:0] hs_force_off_ff;
  logic [`PINS-1:0] ls_force_off_ff;
  nv_state_t nv_state_ff;
  nv_state_t nxt_nv_state;
  logic [`DATA_W-1:0] rdata_ff;
  logic [`DATA_W-1:0] nxt_rdata;
  logic [`PINS-1:0] hs_drive_ff;
  logic [`PINS-1:0] ls_drive_ff;
  logic hs_sel;
  logic ls_sel;
  logic nv_write;

  assign hs_sel = req.wr && (req.addr == `OFS_HS_FORCE_OFF);
  assign ls_sel = req.wr && (req.addr == `OFS_LS_FORCE_OFF);
  assign nv_write = nv_state_ff == NV_OPEN;

  always_ff @(posedge clk) begin
    if (rst) begin
      ol_thresh_ff <= `RST_OL_THRESH;
    end else if (req.wr && req.addr == `OFS_OL_THRESH) begin
      ol_thresh_ff <= req.wdata;
    end
  end

  // ****************************************
  // Restricted write access
  // ****************************************
  always_comb begin
    nxt_nv_state = nv_state_ff;
    case (nv_state_ff)
      NV_LOCKED: begin
        if (req.wr && req.addr == `OFS_NV_UNLOCK && req.wdata == `NV_UNLOCK_KEY) begin
          nxt_nv_state = NV_OPEN;
        end
      end
      NV_OPEN: begin
        if (hs_sel || ls_sel || (req.wr && req.addr == `OFS_NV_UNLOCK)) begin
          nxt_nv_state = NV_LOCKED;
        end
      end
      default: nxt_nv_state = NV_LOCKED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nv_state_ff <= NV_LOCKED;
    end else begin
      nv_state_ff <= nxt_nv_state;
    end
  end

  // Overrides from factory preset, changed only when unlocked
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_force_off_ff <= `FACTORY_FORCE_OFF;
      ls_force_off_ff <= `FACTORY_FORCE_OFF;
    end else begin
      if (hs_sel && nv_write) begin
        hs_force_off_ff <= req.wdata;
      end
      if (ls_sel && nv_write) begin
        ls_force_off_ff <= req.wdata;
      end
    end
  end

  // ****************************************
  // Driver gating
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_drive_ff <= `ZERO_BYTE;
      ls_drive_ff <= `ZERO_BYTE;
    end else begin
      hs_drive_ff <= pin_req.hs_req & ~hs_force_off_ff;
      ls_drive_ff <= pin_req.ls_req & ~ls_force_off_ff;
    end
  end

  assign hs_drive = hs_drive_ff;
  assign ls_drive = ls_drive_ff;
  assign open_load_threshold_sel = ol_thresh_ff;

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    nxt_rdata = `ZERO_BYTE;
    if (req.rd) begin
      case (req.addr)
        `OFS_OL_THRESH: nxt_rdata = ol_thresh_ff;
        `OFS_HS_FORCE_OFF: nxt_rdata = hs_force_off_ff;
        `OFS_LS_FORCE_OFF: nxt_rdata = ls_force_off_ff;
        `OFS_NV_STATUS: nxt_rdata = {{(`DATA_W-1){1'b0}}, nv_write};
        default: nxt_rdata = `ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= `ZERO_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ****************************************
  // Checks
  // ****************************************
  AST_THRESH_WRITE: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH |=> open_load_threshold_sel == $past(req.wdata))
    else $error("threshold write lost");
  AST_HS_PASS: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[0] && pin_req.hs_req[0] && $stable(hs_force_off_ff) |=> hs_drive[0])
    else $error("high-side request blocked");
  AST_HS_OFF: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[7] && $stable(hs_force_off_ff) |=> !hs_drive[7])
    else $error("high-side not forced off");
  AST_HS_MAP: assert property (@(posedge clk) disable iff (rst)
    hs_sel && nv_write |=> hs_force_off_ff == $past(req.wdata))
    else $error("high-side map wrong");
  AST_LS_PASS: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[3] && pin_req.ls_req[3] && $stable(ls_force_off_ff) |=> ls_drive[3])
    else $error("low-side request blocked");
  AST_LS_OFF: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[0] && $stable(ls_force_off_ff) |=> !ls_drive[0])
    else $error("low-side not forced off");
  AST_LS_MAP: assert property (@(posedge clk) disable iff (rst)
    ls_sel && nv_write |=> ls_force_off_ff[3] == $past(req.wdata[3]))
    else $error("low-side pin4 map wrong");
  AST_LS_LOW: assert property (@(posedge clk) disable iff (rst)
    ls_sel && nv_write |=> ls_force_off_ff[2:0] == $past(req.wdata[2:0]))
    else $error("low-side pins 3..1 map wrong");
  AST_LOCKED: assert property (@(posedge clk) disable iff (rst)
    (hs_sel || ls_sel) && !nv_write |=> $stable(hs_force_off_ff) && $stable(ls_force_off_ff))
    else $error("locked override changed");
  AST_FACTORY: assert property (@(posedge clk)
    $past(rst) |-> hs_force_off_ff == `FACTORY_FORCE_OFF && ls_force_off_ff == `FACTORY_FORCE_OFF)
    else $error("override not factory zero");
  AST_RDATA: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `OFS_HS_FORCE_OFF |=> rdata == $past(hs_force_off_ff))
    else $error("read data wrong");
  AST_HS_OFF_P1: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[0] |=> !hs_drive[0])
    else $error("pin1 high-side not forced off");
  AST_HS_OFF_P2: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[1] |=> !hs_drive[1])
    else $error("pin2 high-side not forced off");
  AST_HS_OFF_P3: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[2] |=> !hs_drive[2])
    else $error("pin3 high-side not forced off");
  AST_HS_OFF_P4: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[3] |=> !hs_drive[3])
    else $error("pin4 high-side not forced off");
  AST_HS_OFF_P5: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[4] |=> !hs_drive[4])
    else $error("pin5 high-side not forced off");
  AST_HS_OFF_P6: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[5] |=> !hs_drive[5])
    else $error("pin6 high-side not forced off");
  AST_HS_OFF_P7: assert property (@(posedge clk) disable iff (rst)
    hs_force_off_ff[6] |=> !hs_drive[6])
    else $error("pin7 high-side not forced off");
  AST_LS_OFF_P2: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[1] |=> !ls_drive[1])
    else $error("pin2 low-side not forced off");
  AST_LS_OFF_P3: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[2] |=> !ls_drive[2])
    else $error("pin3 low-side not forced off");
  AST_LS_OFF_P4: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[3] |=> !ls_drive[3])
    else $error("pin4 low-side not forced off");
  AST_LS_OFF_P5: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[4] |=> !ls_drive[4])
    else $error("pin5 low-side not forced off");
  AST_LS_OFF_P6: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[5] |=> !ls_drive[5])
    else $error("pin6 low-side not forced off");
  AST_LS_OFF_P7: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[6] |=> !ls_drive[6])
    else $error("pin7 low-side not forced off");
  AST_LS_OFF_P8: assert property (@(posedge clk) disable iff (rst)
    ls_force_off_ff[7] |=> !ls_drive[7])
    else $error("pin8 low-side not forced off");
  AST_HS_PASS_P2: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[1] && pin_req.hs_req[1] |=> hs_drive[1])
    else $error("pin2 high-side request blocked");
  AST_HS_PASS_P3: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[2] && pin_req.hs_req[2] |=> hs_drive[2])
    else $error("pin3 high-side request blocked");
  AST_HS_PASS_P4: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[3] && pin_req.hs_req[3] |=> hs_drive[3])
    else $error("pin4 high-side request blocked");
  AST_HS_PASS_P5: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[4] && pin_req.hs_req[4] |=> hs_drive[4])
    else $error("pin5 high-side request blocked");
  AST_HS_PASS_P6: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[5] && pin_req.hs_req[5] |=> hs_drive[5])
    else $error("pin6 high-side request blocked");
  AST_HS_PASS_P7: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[6] && pin_req.hs_req[6] |=> hs_drive[6])
    else $error("pin7 high-side request blocked");
  AST_HS_PASS_P8: assert property (@(posedge clk) disable iff (rst)
    !hs_force_off_ff[7] && pin_req.hs_req[7] |=> hs_drive[7])
    else $error("pin8 high-side request blocked");
  AST_LS_PASS_P1: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[0] && pin_req.ls_req[0] |=> ls_drive[0])
    else $error("pin1 low-side request blocked");
  AST_LS_PASS_P2: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[1] && pin_req.ls_req[1] |=> ls_drive[1])
    else $error("pin2 low-side request blocked");
  AST_LS_PASS_P3: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[2] && pin_req.ls_req[2] |=> ls_drive[2])
    else $error("pin3 low-side request blocked");
  AST_LS_PASS_P5: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[4] && pin_req.ls_req[4] |=> ls_drive[4])
    else $error("pin5 low-side request blocked");
  AST_LS_PASS_P6: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[5] && pin_req.ls_req[5] |=> ls_drive[5])
    else $error("pin6 low-side request blocked");
  AST_LS_PASS_P7: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[6] && pin_req.ls_req[6] |=> ls_drive[6])
    else $error("pin7 low-side request blocked");
  AST_LS_PASS_P8: assert property (@(posedge clk) disable iff (rst)
    !ls_force_off_ff[7] && pin_req.ls_req[7] |=> ls_drive[7])
    else $error("pin8 low-side request blocked");
  AST_OLT_P8: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH |=> open_load_threshold_sel[7:6] == $past(req.wdata[7:6]))
    else $error("pin8 threshold field wrong");
  AST_OLT_P7: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH |=> open_load_threshold_sel[5:4] == $past(req.wdata[5:4]))
    else $error("pin7 threshold field wrong");
  AST_OLT_P6: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH |=> open_load_threshold_sel[3:2] == $past(req.wdata[3:2]))
    else $error("pin6 threshold field wrong");
  AST_OLT_P5: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH |=> open_load_threshold_sel[1:0] == $past(req.wdata[1:0]))
    else $error("pin5 threshold field wrong");
  AST_LS_READ: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `OFS_LS_FORCE_OFF |=> rdata == $past(ls_force_off_ff))
    else $error("low-side read data wrong");
  AST_OLT_READ: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `OFS_OL_THRESH |=> rdata == $past(ol_thresh_ff))
    else $error("threshold read data wrong");
  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `OFS_NV_STATUS |=> rdata[0] == $past(nv_write))
    else $error("status read data wrong");
  AST_IDLE_READ: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> rdata == `ZERO_BYTE)
    else $error("read data not idle zero");
  AST_UNLOCK: assert property (@(posedge clk) disable iff (rst)
    !nv_write && req.wr && req.addr == `OFS_NV_UNLOCK && req.wdata == `NV_UNLOCK_KEY |=> nv_write)
    else $error("unlock key not accepted");
  AST_RELOCK: assert property (@(posedge clk) disable iff (rst)
    nv_write && (hs_sel || ls_sel) |=> !nv_write)
    else $error("override write did not relock");

  // ****************************************
  // Coverage
  // ****************************************
  COV_UNLOCK_WRITE: cover property (@(posedge clk) disable iff (rst) hs_sel && nv_write);
  COV_LOCKED_WRITE: cover property (@(posedge clk) disable iff (rst) ls_sel && !nv_write);
  COV_FORCED: cover property (@(posedge clk) disable iff (rst)
    |(pin_req.hs_req & hs_force_off_ff));
  COV_THRESH_WRITE: cover property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `OFS_OL_THRESH);
endmodule
`default_nettype wire

// ==== verif/test_hv_io_driver_override_config.sv ====
// Testbench for the driver override register bank.
// Assumes the design, its package and hv_io_cfg.svh are compiled first.
`default_nettype none
`include "hv_io_cfg.svh"
module test_hv_io_driver_override_config;
  import hv_io_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  drv_req_t pin_req = '0;
  logic [7:0] rdata;
  logic [7:0] hs_drive;
  logic [7:0] ls_drive;
  logic [7:0] olt;
  int errors = 0;
  int num_checks = 0;
  // Rows: high-side force-off, low-side force-off, high-side request, low-side request
  logic [31:0] rows [5] = '{32'h0000_ffff, 32'hffff_ffff, 32'h8001_ffff, 32'h0108_a55a,
                            32'h55aa_f00f};
  hv_io_driver_override_config i_hv_io_driver_override_config (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .pin_req(pin_req),
    .hs_drive(hs_drive), .ls_drive(ls_drive), .open_load_threshold_sel(olt));
  initial forever #5 clk = ~clk;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk);
    req <= '{a, d, w, r};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    bus(a, 8'h00, 1'b0, 1'b1);
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic unlock();
    bus(`OFS_NV_UNLOCK, `NV_UNLOCK_KEY, 1'b1, 1'b0);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    print_verdict();
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_HS_FORCE_OFF, `FACTORY_FORCE_OFF, "hs reset");
    rd(`OFS_LS_FORCE_OFF, `FACTORY_FORCE_OFF, "ls reset");
    rd(`OFS_OL_THRESH, `RST_OL_THRESH, "olt reset");
    for (int i = 0; i < 5; i++) begin
      unlock();
      rd(`OFS_NV_STATUS, 8'h01, "unlocked");
      bus(`OFS_HS_FORCE_OFF, rows[i][31:24], 1'b1, 1'b0);
      rd(`OFS_NV_STATUS, 8'h00, "relocked");
      unlock();
      bus(`OFS_LS_FORCE_OFF, rows[i][23:16], 1'b1, 1'b0);
      pin_req <= '{rows[i][15:8], rows[i][7:0]};
      repeat (3) @(posedge clk);
      #1;
      chk("hs_drive", rows[i][15:8] & ~rows[i][31:24], hs_drive);
      chk("ls_drive", rows[i][7:0] & ~rows[i][23:16], ls_drive);
      rd(`OFS_HS_FORCE_OFF, rows[i][31:24], "hs read");
      rd(`OFS_LS_FORCE_OFF, rows[i][23:16], "ls read");
    end
    // Locked and wrong-key writes are dropped
    bus(`OFS_HS_FORCE_OFF, 8'h00, 1'b1, 1'b0);
    bus(`OFS_NV_UNLOCK, 8'h5a, 1'b1, 1'b0);
    bus(`OFS_LS_FORCE_OFF, 8'h00, 1'b1, 1'b0);
    rd(`OFS_HS_FORCE_OFF, 8'h55, "hs locked");
    rd(`OFS_LS_FORCE_OFF, 8'haa, "ls locked");
    rd(8'h10, 8'h00, "unmapped");
    for (int k = 0; k < 2; k++) begin
      bus(`OFS_OL_THRESH, k ? 8'h1b : 8'he4, 1'b1, 1'b0);
      rd(`OFS_OL_THRESH, k ? 8'h1b : 8'he4, "olt read");
      chk("olt out", k ? 8'h1b : 8'he4, olt);
    end
    // Mid-run reset reloads factory zero
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_HS_FORCE_OFF, `FACTORY_FORCE_OFF, "hs after rst");
    repeat (2) @(posedge clk);
    #1;
    chk("hs_drive after rst", pin_req.hs_req, hs_drive);
    print_verdict();
  end
endmodule
`default_nettype wire
